/* File: logic/rtm_monitor.sv */
// reference retention, analog reference loss and torque detection
// assumes analog and torque values arrive sampled on mclk_i, while the
// power-fail and save-key levels come straight from pins
// What this block does
// - mode 0 saves reference at power loss
// - mode 1 saves only on save key
// - loss when input below tenth within window
// - loss flag on terminal function 33
// - ratio 0 stop, 20-120 scale, 999 cancel
// - fallback is held sample times ratio
// - rising above recovery threshold ends loss
// - ratio 999 flags but keeps following input
// - ratio 0 or 999 recovers at fifth
// - ratio 100 to 120 recovers at sample
// - sample reference at a fixed interval
// - detection uses the unfiltered input value
// - levels 0-300, timers 0.01-600 s, defaults
// - codes 46, 47, 45; shared level two
// - over flag after timer above level
// - over flag clears below level minus 5
// - low flag after timer below level
// - low flag clears above level plus 5
// - each torque flag stays on 100 ms
// - low flag frozen under fifth of base
// - run inputs default to 98 and 99
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module rtm_monitor #(
  parameter int TICK_CYCLES = rtm_pkg::RTM_TICK_CYC // cycles per 10 ms tick
) (
  input wire logic mclk_i, // control clock
  input wire logic reset_n_i, // power-on reset
  input wire logic [7:0] addr_i, // register address
  input wire logic [15:0] wdata_i, // register write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [15:0] rdata_o, // read data, cycle after rd_i
  input wire logic [15:0] analog_voltage_input_i, // sampled voltage ref
  input wire logic [15:0] analog_current_input_i, // sampled current ref
  input wire logic [15:0] analog_aux_input_i, // sampled aux ref
  input wire logic [9:0] torque_calc_i, // calculated torque, %
  input wire logic [9:0] torque_cmd_i, // torque command, %
  input wire logic [15:0] out_freq_i, // output frequency
  input wire logic power_fail_i, // main power lost, pin
  input wire logic save_key_i, // save key pressed, pin
  input wire logic [15:0] nv_data_i, // stored reference at power-up
  output logic nv_we_o, // store pulse
  output logic [15:0] nv_data_o, // value to store
  output logic [15:0] ref_freq_o, // reference frequency in use
  output logic decel_stop_o, // ordered to decelerate to stop
  output logic reference_loss_flag_o, // analog reference lost
  output logic torque_over_flag_one_o, // torque over one
  output logic torque_over_flag_two_o, // torque over two
  output logic low_torque_flag_o, // low torque
  output logic [1:0] term_o, // output terminal levels
  output logic [7:0] forward_run_input_fn_o, // forward input function
  output logic [7:0] reverse_run_input_fn_o // reverse input function
);
  import rtm_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES + 1); // tick counter width
  // ratio code that raises the flag but keeps following the input
  localparam logic [9:0] RATIO_CANCEL = RTM_RATIO_RST; // 999

  // whole module state
  typedef struct packed {
    rtm_ret_t mode; // retention mode
    logic [15:0] keypad_ref; // working keypad reference
    logic [9:0] ratio; // loss ratio setting
    logic [1:0][9:0] lvl; // torque levels
    logic [1:0][15:0] tmr; // torque timers, ticks
    logic [1:0][7:0] term_sel; // terminal function codes
    logic [7:0] fwd_fn; // forward input function
    logic [7:0] rev_fn; // reverse input function
    logic [15:0] base_freq; // base frequency
    logic [1:0] src; // reference source
    logic [15:0] rdata; // read answer
    logic pf_s1, pf_s2, pf_d; // power-fail synchroniser
    logic sk_s1, sk_s2, sk_d; // save-key synchroniser
    logic restored; // power-up restore done
    logic nv_we; // store pulse
    logic [15:0] nv_data; // store value
    logic [TW-1:0] tick_cnt; // tick divider
    logic [5:0] win_cnt; // ticks within sample window
    logic [15:0] f1; // last sample, held through loss
    logic loss; // reference lost
    logic [15:0] ref_out; // reference in use
    logic decel; // stop request
    logic [2:0][15:0] det_cnt; // detection timers
    logic [2:0] flag; // torque flags: over1, over2, low
    logic [2:0][3:0] on_cnt; // on-time ticks
    logic [1:0] term; // terminal levels
  } rtm_state_t;

  // s is the registered state, n its next value
  rtm_state_t s, n;

  logic pf_rise; // power fail edge
  logic sk_rise; // save key edge
  logic tick; // 10 ms enable
  logic win_end; // sample window over
  logic [15:0] ana; // chosen analog reference
  logic analog_src; // source is analog
  logic [15:0] fb; // fallback frequency
  logic [15:0] thr; // recovery threshold
  logic drop; // sharp drop seen
  logic low_zone; // below fifth of base
  logic [2:0] trig; // detection condition
  logic [2:0] rel; // release condition

  // edges compare the second stage with its delayed copy
  assign pf_rise = s.pf_s2 & ~s.pf_d;
  assign sk_rise = s.sk_s2 & ~s.sk_d;
  // 10 ms enable from the control clock
  assign tick = (s.tick_cnt == TW'(TICK_CYCLES - 1));
  assign win_end = tick && (s.win_cnt == RTM_LOSS_WIN_TICKS - 6'h01);
  // raw input, no filter in the path
  assign ana = (s.src == 2'h0) ? analog_voltage_input_i :
               (s.src == 2'h1) ? analog_current_input_i : analog_aux_input_i;
  assign analog_src = (s.src != 2'h3);
  // fallback scales the held sample
  assign fb = 16'((32'(s.f1) * 32'(s.ratio)) / 32'd100);
  // recovery level depends on the ratio
  assign thr = (s.ratio == RTM_RATIO_STOP || s.ratio == RATIO_CANCEL)
             ? 16'(s.f1 / 16'd5)
             : (s.ratio >= RTM_RATIO_FULL) ? s.f1
             : fb;
  // below a tenth of the held sample
  assign drop = analog_src && (s.f1 != 16'h0000) &&
                ({4'h0, ana} * 20'd10 < {4'h0, s.f1});
  assign low_zone = ({3'h0, out_freq_i} * 19'd5 < {3'h0, s.base_freq});
  // torque comparisons, either source triggers
  assign trig[0] = (torque_calc_i > s.lvl[0]) || (torque_cmd_i > s.lvl[0]);
  assign trig[1] = (torque_calc_i > s.lvl[1]) || (torque_cmd_i > s.lvl[1]);
  assign trig[2] = (torque_calc_i < s.lvl[1]) || (torque_cmd_i < s.lvl[1]);
  // release uses calculated torque and 5 % band
  assign rel[0] = ({1'b0, torque_calc_i} + RTM_HYST < {1'b0, s.lvl[0]});
  assign rel[1] = ({1'b0, torque_calc_i} + RTM_HYST < {1'b0, s.lvl[1]});
  assign rel[2] = ({1'b0, torque_calc_i} > {1'b0, s.lvl[1]} + RTM_HYST);

  // next-state logic
  always_comb begin
    n = s;
    n.nv_we = 1'b0;
    n.rdata = 16'h0000;
    // pins pass two flops
    n.pf_s1 = power_fail_i;
    n.pf_s2 = s.pf_s1;
    n.pf_d = s.pf_s2;
    n.sk_s1 = save_key_i;
    n.sk_s2 = s.sk_s1;
    n.sk_d = s.sk_s2;
    // first cycle after reset: restore stored reference
    if (!s.restored) begin
      n.restored = 1'b1;
      n.keypad_ref = nv_data_i;
    end
    // register writes
    if (wr_i) begin
      unique case (addr_i)
        RTM_CTRL_OFS: n.mode = rtm_ret_t'(wdata_i[0]);
        RTM_KEYREF_OFS: n.keypad_ref = wdata_i;
        RTM_RATIO_OFS: begin
          // only legal settings are taken
          if (wdata_i == 16'(RTM_RATIO_STOP) || wdata_i == 16'(RATIO_CANCEL) ||
              (wdata_i >= 16'(RTM_RATIO_MIN) &&
               wdata_i <= 16'(RTM_RATIO_MAX))) begin
            n.ratio = wdata_i[9:0];
          end
        end
        RTM_LVL1_OFS: n.lvl[0] = (wdata_i > 16'(RTM_LVL_MAX)) ? RTM_LVL_MAX : wdata_i[9:0];
        RTM_LVL2_OFS: n.lvl[1] = (wdata_i > 16'(RTM_LVL_MAX)) ? RTM_LVL_MAX : wdata_i[9:0];
        RTM_TMR1_OFS: n.tmr[0] = (wdata_i < RTM_TMR_MIN) ? RTM_TMR_MIN :
                                 (wdata_i > RTM_TMR_MAX) ? RTM_TMR_MAX : wdata_i;
        RTM_TMR2_OFS: n.tmr[1] = (wdata_i < RTM_TMR_MIN) ? RTM_TMR_MIN :
                                 (wdata_i > RTM_TMR_MAX) ? RTM_TMR_MAX : wdata_i;
        RTM_TERM0_OFS: n.term_sel[0] = wdata_i[7:0];
        RTM_TERM1_OFS: n.term_sel[1] = wdata_i[7:0];
        RTM_FWDFN_OFS: n.fwd_fn = wdata_i[7:0];
        RTM_REVFN_OFS: n.rev_fn = wdata_i[7:0];
        RTM_BASE_OFS: n.base_freq = wdata_i;
        RTM_SRC_OFS: n.src = wdata_i[1:0];
        default: ; // read-only or unmapped: ignored
      endcase
    end
    // register reads, answer only in next cycle
    if (rd_i) begin
      unique case (addr_i)
        RTM_CTRL_OFS: n.rdata = {15'h0000, s.mode};
        RTM_KEYREF_OFS: n.rdata = s.keypad_ref;
        RTM_RATIO_OFS: n.rdata = {6'h00, s.ratio};
        RTM_LVL1_OFS: n.rdata = {6'h00, s.lvl[0]};
        RTM_LVL2_OFS: n.rdata = {6'h00, s.lvl[1]};
        RTM_TMR1_OFS: n.rdata = s.tmr[0];
        RTM_TMR2_OFS: n.rdata = s.tmr[1];
        RTM_TERM0_OFS: n.rdata = {8'h00, s.term_sel[0]};
        RTM_TERM1_OFS: n.rdata = {8'h00, s.term_sel[1]};
        RTM_FWDFN_OFS: n.rdata = {8'h00, s.fwd_fn};
        RTM_REVFN_OFS: n.rdata = {8'h00, s.rev_fn};
        RTM_BASE_OFS: n.rdata = s.base_freq;
        RTM_SRC_OFS: n.rdata = {14'h0000, s.src};
        RTM_STAT_OFS: n.rdata = {8'h00, low_zone, s.term, s.decel, s.flag, s.loss}; // 8 bits
        RTM_REFOUT_OFS: n.rdata = s.ref_out;
        RTM_F1_OFS: n.rdata = s.f1;
        default: n.rdata = 16'h0000; // unmapped reads zero
      endcase
    end
    // retention: auto save on power loss
    if (s.mode == RTM_RET_AUTO && pf_rise) begin
      n.nv_we = 1'b1;
      n.nv_data = s.keypad_ref;
    end
    // retention: save key only, power loss discards
    if (s.mode == RTM_RET_KEY && sk_rise) begin
      n.nv_we = 1'b1;
      n.nv_data = s.keypad_ref;
    end
    // tick divider and sample window
    n.tick_cnt = tick ? '0 : s.tick_cnt + TW'(1);
    if (tick) begin
      n.win_cnt = win_end ? 6'h00 : s.win_cnt + 6'h01;
    end
    // loss detection and recovery; a drop outranks the window
    // sample, so the held value stays the one from before the loss
    if (!analog_src) begin
      n.loss = 1'b0;
    end else if (!s.loss && drop) begin
      n.loss = 1'b1; // f1 kept as pre-loss sample
    end else if (s.loss && ana > thr) begin
      n.loss = 1'b0;
    end else if (!s.loss && win_end) begin
      n.f1 = ana;
    end
    // reference selection
    // loss with ratio 0 orders a stop instead of a frequency
    if (!analog_src) begin
      n.ref_out = s.keypad_ref;
      n.decel = 1'b0;
    end else if (!s.loss || s.ratio == RTM_RATIO_RST) begin
      n.ref_out = ana;
      n.decel = 1'b0;
    end else if (s.ratio == RTM_RATIO_STOP) begin
      n.ref_out = 16'h0000;
      n.decel = 1'b1;
    end else begin
      n.ref_out = fb;
      n.decel = 1'b0;
    end
    // three torque detectors; two and low share one setting
    // the low detector freezes whole, on-time count included, in the low zone
    for (int k = 0; k < 3; k++) begin
      if (!(k == 2 && low_zone)) begin
        // timer restarts whenever condition drops
        if (!trig[k]) begin
          n.det_cnt[k] = 16'h0000;
        end else if (tick && s.det_cnt[k] != 16'hFFFF) begin
          n.det_cnt[k] = s.det_cnt[k] + 16'h0001;
        end
        // on-time count and release
        if (s.flag[k]) begin
          if (tick && s.on_cnt[k] < RTM_MIN_ON_TICKS) begin
            n.on_cnt[k] = s.on_cnt[k] + 4'h1;
          end
          if (rel[k] && s.on_cnt[k] >= RTM_MIN_ON_TICKS) begin
            n.flag[k] = 1'b0;
          end
        end
        // set after timer, wins over release
        if (trig[k] && tick && (s.det_cnt[k] + 16'h0001 >= s.tmr[(k == 0) ? 0 : 1])) begin
          n.flag[k] = 1'b1;
          if (!s.flag[k]) begin
            n.on_cnt[k] = 4'h0;
          end
        end
      end
    end
    // output terminal routing
    for (int t = 0; t < 2; t++) begin
      unique case (s.term_sel[t])
        RTM_FN_LOSS: n.term[t] = s.loss;
        RTM_FN_TD1: n.term[t] = s.flag[0];
        RTM_FN_TD2: n.term[t] = s.flag[1];
        RTM_FN_LOW: n.term[t] = s.flag[2];
        default: n.term[t] = 1'b0;
      endcase
    end
  end

  // state register
  // reset loads constants only; the stored reference comes after release
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= '0;
      s.ratio <= RTM_RATIO_RST;
      s.lvl[0] <= RTM_LVL1_RST;
      s.lvl[1] <= RTM_LVL2_RST;
      s.tmr[0] <= RTM_TMR1_RST;
      s.tmr[1] <= RTM_TMR2_RST;
      s.fwd_fn <= RTM_FWDFN_RST;
      s.rev_fn <= RTM_REVFN_RST;
      s.base_freq <= RTM_BASE_RST;
    end else begin
      s <= n;
    end
  end

  // outputs, all from flops
  assign rdata_o = s.rdata;
  assign nv_we_o = s.nv_we;
  assign nv_data_o = s.nv_data;
  assign ref_freq_o = s.ref_out;
  assign decel_stop_o = s.decel;
  assign reference_loss_flag_o = s.loss;
  assign torque_over_flag_one_o = s.flag[0];
  assign torque_over_flag_two_o = s.flag[1];
  assign low_torque_flag_o = s.flag[2];
  assign term_o = s.term;
  assign forward_run_input_fn_o = s.fwd_fn;
  assign reverse_run_input_fn_o = s.rev_fn;

  // checks
  // all checks sample on the rising edge and pause during reset
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  sequence pf_auto_s;
    pf_rise && s.mode == RTM_RET_AUTO;
  endsequence
  sequence stored_s;
    nv_we_o && nv_data_o == $past(s.keypad_ref);
  endsequence

  auto_save_a: assert property (pf_auto_s |=> stored_s)
    else $error("power loss did not store reference");
  key_only_a: assert property (pf_rise && !sk_rise && s.mode == RTM_RET_KEY |=> !nv_we_o)
    else $error("power loss stored in key mode");
  loss_detect_a: assert property (!s.loss && drop |=> reference_loss_flag_o)
    else $error("drop did not raise loss");
  loss_term_a: assert property (s.term_sel[0] == RTM_FN_LOSS |=> term_o[0] == $past(s.loss))
    else $error("terminal 0 does not show loss");
  fallback_ref_a: assert property (s.loss && analog_src && s.ratio >= RTM_RATIO_MIN &&
      s.ratio <= RTM_RATIO_MAX |=> ref_freq_o == $past(fb))
    else $error("fallback frequency wrong");
  recover_a: assert property (s.loss && analog_src && ana > thr |=> !reference_loss_flag_o)
    else $error("loss not cleared on recovery");
  cancel_follow_a: assert property (analog_src && s.ratio == RTM_RATIO_RST |=>
      ref_freq_o == $past(ana))
    else $error("cancel setting changed reference");
  min_on_a: assert property ($fell(s.flag[0]) |-> $past(s.on_cnt[0]) >= RTM_MIN_ON_TICKS)
    else $error("torque flag shorter than least on-time");
  low_freeze_a: assert property ($past(low_zone) |-> s.flag[2] == $past(s.flag[2]))
    else $error("low flag changed in low zone");
  timer_restart_a: assert property (!trig[0] |=> s.det_cnt[0] == 16'h0000)
    else $error("timer not restarted");
  // ratio 0 turns the loss into a stop order
  stop_order_a: assert property (s.loss && analog_src &&
      s.ratio == RTM_RATIO_STOP |=> decel_stop_o && ref_freq_o == 16'h0000)
    else $error("stop not ordered on loss");
  // ratio 0 or 999: above a fifth of the held sample the loss ends
  fifth_recover_a: assert property (s.loss && analog_src &&
      (s.ratio == RTM_RATIO_STOP || s.ratio == RATIO_CANCEL) &&
      {4'h0, ana} * 20'd5 > {4'h0, s.f1} |=> !reference_loss_flag_o)
    else $error("loss kept above a fifth");
  // ratio 100 to 120: only the held sample itself ends the loss
  full_recover_a: assert property (s.loss && analog_src &&
      s.ratio >= RTM_RATIO_FULL && s.ratio != RATIO_CANCEL &&
      ana <= s.f1 |=> reference_loss_flag_o)
    else $error("loss ended below held sample");
  // over flag one never drops while its release band is not reached
  over_hold_a: assert property (s.flag[0] && !rel[0] |=> torque_over_flag_one_o)
    else $error("over flag dropped inside band");
  // past its on-time and above the band the low flag clears
  low_release_a: assert property (s.flag[2] && !low_zone && rel[2] && !trig[2] &&
      s.on_cnt[2] >= RTM_MIN_ON_TICKS |=> !low_torque_flag_o)
    else $error("low flag not released");
endmodule // rtm_monitor
`default_nettype wire

/* File: logic/rtm_pkg.sv */
// constants shared by the reference and torque monitor
// assumes a single 10 MHz control clock and a plain register port
`default_nettype none
package rtm_pkg;
  // register offsets, byte addresses on an 8-bit address port
  localparam logic [7:0] RTM_CTRL_OFS = 8'h00; // retention mode
  localparam logic [7:0] RTM_KEYREF_OFS = 8'h04; // keypad reference
  localparam logic [7:0] RTM_RATIO_OFS = 8'h08; // loss ratio setting
  localparam logic [7:0] RTM_LVL1_OFS = 8'h0C; // torque level one
  localparam logic [7:0] RTM_TMR1_OFS = 8'h10; // torque timer one
  localparam logic [7:0] RTM_LVL2_OFS = 8'h14; // shared level two / low
  localparam logic [7:0] RTM_TMR2_OFS = 8'h18; // shared timer two / low
  localparam logic [7:0] RTM_TERM0_OFS = 8'h1C; // terminal 0 function
  localparam logic [7:0] RTM_TERM1_OFS = 8'h20; // terminal 1 function
  localparam logic [7:0] RTM_FWDFN_OFS = 8'h24; // forward run function
  localparam logic [7:0] RTM_REVFN_OFS = 8'h28; // reverse run function
  localparam logic [7:0] RTM_BASE_OFS = 8'h2C; // base frequency
  localparam logic [7:0] RTM_SRC_OFS = 8'h30; // reference source
  localparam logic [7:0] RTM_STAT_OFS = 8'h34; // flags, read only
  localparam logic [7:0] RTM_REFOUT_OFS = 8'h38; // reference out, read only
  localparam logic [7:0] RTM_F1_OFS = 8'h3C; // held sample, read only
  // reset values
  localparam logic [9:0] RTM_RATIO_RST = 10'h3E7; // 999, cancel
  localparam logic [9:0] RTM_LVL1_RST = 10'h064; // 100 %
  localparam logic [15:0] RTM_TMR1_RST = 16'h03E8; // 10.00 s
  localparam logic [9:0] RTM_LVL2_RST = 10'h014; // 20 %
  localparam logic [15:0] RTM_TMR2_RST = 16'h07D0; // 20.00 s
  localparam logic [7:0] RTM_FWDFN_RST = 8'h62; // 98
  localparam logic [7:0] RTM_REVFN_RST = 8'h63; // 99
  localparam logic [15:0] RTM_BASE_RST = 16'h01F4; // 50.0 Hz in 0.1 Hz
  // setting limits
  localparam logic [9:0] RTM_RATIO_STOP = 10'h000; // decelerate to stop
  localparam logic [9:0] RTM_RATIO_MIN = 10'h014; // 20 %
  localparam logic [9:0] RTM_RATIO_MAX = 10'h078; // 120 %
  localparam logic [9:0] RTM_RATIO_FULL = 10'h064; // 100 %
  localparam logic [9:0] RTM_LVL_MAX = 10'h12C; // 300 %
  localparam logic [15:0] RTM_TMR_MIN = 16'h0001; // 0.01 s
  localparam logic [15:0] RTM_TMR_MAX = 16'hEA60; // 600.00 s
  localparam logic [10:0] RTM_HYST = 11'h005; // 5 % of rated torque
  // output terminal function codes
  localparam logic [7:0] RTM_FN_LOSS = 8'h21; // 33
  localparam logic [7:0] RTM_FN_LOW = 8'h2D; // 45
  localparam logic [7:0] RTM_FN_TD1 = 8'h2E; // 46
  localparam logic [7:0] RTM_FN_TD2 = 8'h2F; // 47
  // timing
  localparam int RTM_CLK_HZ = 10_000_000; // control clock rate
  localparam int RTM_TICK_MS = 10; // timer tick period
  localparam int RTM_TICK_CYC = RTM_CLK_HZ / 1000 * RTM_TICK_MS;
  localparam int RTM_LOSS_WIN_MS = 400; // sampling interval
  localparam logic [5:0] RTM_LOSS_WIN_TICKS = 6'(RTM_LOSS_WIN_MS / RTM_TICK_MS);
  localparam int RTM_MIN_ON_MS = 100; // least flag on-time
  localparam logic [3:0] RTM_MIN_ON_TICKS = 4'(RTM_MIN_ON_MS / RTM_TICK_MS);
  // retention modes
  typedef enum logic {RTM_RET_AUTO = 1'b0, RTM_RET_KEY = 1'b1} rtm_ret_t;
endpackage : rtm_pkg
`default_nettype wire

/* File: sim/rtm_ref_source.sv */
// far-side model: analog reference channels and output terminal load
// assumes the bench commands the voltage level on the shared clock
`timescale 1ns/1ps
`default_nettype none
module rtm_ref_source (
  input wire logic mclk_i, // control clock
  input wire logic [15:0] level_i, // commanded voltage level
  input wire logic [1:0] term_i, // terminal levels from the monitor
  output logic [15:0] volt_o, // voltage reference channel
  output logic [15:0] cur_o, // unselected current channel
  output logic [15:0] aux_o, // unselected aux channel
  output logic [1:0] term_seen_o // level seen at the terminal load
);
  logic [15:0] wob = 16'h5A5A; // unselected channels never hold still
  // converter sample and terminal load capture
  always_ff @(posedge mclk_i) begin
    volt_o <= level_i;
    wob <= ~wob;
    term_seen_o <= term_i;
  end
  assign cur_o = wob;
  assign aux_o = ~wob;
endmodule // rtm_ref_source
`default_nettype wire

/* File: sim/tb.sv */
// self-checking bench for the reference and torque monitor
// assumes a 10 cycle timer tick, so a 400 cycle loss window
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rtm_pkg::*;
  typedef struct packed {logic w; logic [7:0] a; logic [15:0] d; logic [15:0] e;} rtm_row_t;
  logic mclk_i = 1'b0; // control clock
  logic reset_n_i = 1'b0; // power-on reset
  logic wr_i = 1'b0, rd_i = 1'b0, pf = 1'b0, sk = 1'b0, s;
  logic [7:0] addr_i = 8'h00;
  logic [15:0] wdata_i = 16'h0000, lvl = 16'h03E8, nvin = 16'h0000, ofreq = 16'h0190, v;
  logic [9:0] tq = 10'h000, tc = 10'h000; // calculated torque, command
  wire [15:0] rdata, av, ac, au, nvd, reff;
  wire nvwe, dec, lf, f1, f2, lo;
  wire [1:0] term, tseen;
  wire [7:0] ffn, rfn;
  int failures = 0, num_checks = 0;
  // register rows: write or not, address, data, expected read
  localparam rtm_row_t ROWS [20] = '{
    '{1'b0, RTM_RATIO_OFS, 16'h0000, 16'h03E7}, '{1'b0, RTM_LVL1_OFS, 16'h0000, 16'h0064},
    '{1'b0, RTM_TMR1_OFS, 16'h0000, 16'h03E8}, '{1'b0, RTM_LVL2_OFS, 16'h0000, 16'h0014},
    '{1'b0, RTM_TMR2_OFS, 16'h0000, 16'h07D0}, '{1'b0, RTM_FWDFN_OFS, 16'h0000, 16'h0062},
    '{1'b0, RTM_REVFN_OFS, 16'h0000, 16'h0063}, '{1'b0, RTM_BASE_OFS, 16'h0000, 16'h01F4},
    '{1'b0, RTM_CTRL_OFS, 16'h0000, 16'h0000}, '{1'b0, RTM_STAT_OFS, 16'h0000, 16'h0000},
    '{1'b0, 8'h40, 16'h0000, 16'h0000}, '{1'b1, RTM_RATIO_OFS, 16'h0032, 16'h0032},
    '{1'b1, RTM_RATIO_OFS, 16'h0096, 16'h0032}, '{1'b1, RTM_RATIO_OFS, 16'h0013, 16'h0032},
    '{1'b1, RTM_RATIO_OFS, 16'h0000, 16'h0000}, '{1'b1, RTM_LVL1_OFS, 16'h0190, 16'h012C},
    '{1'b1, RTM_TMR1_OFS, 16'h0000, 16'h0001}, '{1'b1, RTM_TMR1_OFS, 16'hFFFF, 16'hEA60},
    '{1'b1, RTM_STAT_OFS, 16'h00FF, 16'h0000}, '{1'b1, 8'h40, 16'h1234, 16'h0000}};

  rtm_monitor #(.TICK_CYCLES(10)) rtm_monitor_inst (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .analog_voltage_input_i(av),
    .analog_current_input_i(ac), .analog_aux_input_i(au), .torque_calc_i(tq),
    .torque_cmd_i(tc), .out_freq_i(ofreq), .power_fail_i(pf), .save_key_i(sk),
    .nv_data_i(nvin), .nv_we_o(nvwe), .nv_data_o(nvd), .ref_freq_o(reff),
    .decel_stop_o(dec), .reference_loss_flag_o(lf), .torque_over_flag_one_o(f1),
    .torque_over_flag_two_o(f2), .low_torque_flag_o(lo), .term_o(term),
    .forward_run_input_fn_o(ffn), .reverse_run_input_fn_o(rfn));
  rtm_ref_source rtm_ref_source_inst (.mclk_i(mclk_i), .level_i(lvl), .term_i(term),
    .volt_o(av), .cur_o(ac), .aux_o(au), .term_seen_o(tseen));

  // free-running 100 ns clock
  initial begin
    forever #50 mclk_i = ~mclk_i;
  end
  task cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle write strobe
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 d = rdata;
  endtask
  // look for one store pulse within a bounded span
  task nv_wait(output logic sn, output logic [15:0] d);
    sn = 1'b0;
    d = 16'h0000;
    repeat (10) begin
      @(posedge mclk_i);
      #1;
      if (nvwe === 1'b1 && sn === 1'b0) begin
        sn = 1'b1;
        d = nvd;
      end
    end
  endtask
  // settle at 1000, drop, check fallback, then recover in two steps
  task loss_case(input logic [9:0] r, input logic [15:0] lo_v, er, rlo, rhi,
                 input logic ed);
    wr(RTM_RATIO_OFS, {6'h00, r});
    lvl <= 16'h03E8;
    cyc(900);
    chk(reff, 16'h03E8);
    rd(RTM_F1_OFS, v);
    chk(v, 16'h03E8);
    lvl <= lo_v;
    cyc(5);
    chk({15'h0000, lf}, 16'h0001);
    chk({14'h0000, tseen}, 16'h0001);
    chk({15'h0000, dec}, {15'h0000, ed});
    chk(reff, er);
    lvl <= rlo;
    cyc(5);
    chk({15'h0000, lf}, 16'h0001);
    lvl <= rhi;
    cyc(5);
    chk({15'h0000, lf}, 16'h0000);
    chk(reff, rhi);
  endtask
  task give_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // hang guard, runs well past the expected span
  initial begin
    #3_000_000;
    failures++;
    give_verdict();
  end
  // main sequence
  initial begin
    cyc(20);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      if (ROWS[i].w) wr(ROWS[i].a, ROWS[i].d);
      rd(ROWS[i].a, v);
      chk(v, ROWS[i].e);
    end
    $display("register table done");
    wr(RTM_SRC_OFS, 16'h0000);
    wr(RTM_TERM0_OFS, 16'h0021);
    wr(RTM_TERM1_OFS, 16'h002E);
    wr(RTM_LVL1_OFS, 16'h0064);
    wr(RTM_TMR1_OFS, 16'h0005);
    wr(RTM_TMR2_OFS, 16'h0005);
    loss_case(10'h032, 16'h0032, 16'h01F4, 16'h01C2, 16'h0258, 1'b0);
    loss_case(10'h078, 16'h0032, 16'h04B0, 16'h0384, 16'h044C, 1'b0);
    loss_case(10'h064, 16'h0032, 16'h03E8, 16'h0384, 16'h044C, 1'b0);
    loss_case(10'h3E7, 16'h0032, 16'h0032, 16'h0096, 16'h00FA, 1'b0);
    loss_case(10'h000, 16'h0032, 16'h0000, 16'h0096, 16'h00FA, 1'b1);
    $display("reference loss done");
    tq <= 10'h096;
    cyc(30);
    tq <= 10'h032;
    cyc(5);
    tq <= 10'h096;
    cyc(35);
    chk({15'h0000, f1}, 16'h0000);
    cyc(35);
    chk({15'h0000, f1}, 16'h0001);
    chk({15'h0000, tseen[1]}, 16'h0001);
    tq <= 10'h061;
    cyc(150);
    chk({15'h0000, f1}, 16'h0001);
    tq <= 10'h05E;
    cyc(5);
    chk({15'h0000, f1}, 16'h0000);
    tq <= 10'h096;
    cyc(70);
    tq <= 10'h032;
    cyc(50);
    chk({15'h0000, f1}, 16'h0001);
    cyc(80);
    chk({15'h0000, f1}, 16'h0000);
    tq <= 10'h00A;
    cyc(120);
    tq <= 10'h012;
    tc <= 10'h096;
    cyc(70);
    chk({15'h0000, f2}, 16'h0001);
    wr(RTM_TERM0_OFS, 16'h002D);
    tq <= 10'h01E;
    tc <= 10'h01E;
    cyc(120);
    tq <= 10'h00A;
    cyc(70);
    chk({15'h0000, lo}, 16'h0001);
    chk({15'h0000, tseen[0]}, 16'h0001);
    tq <= 10'h018;
    cyc(150);
    chk({15'h0000, lo}, 16'h0001);
    tq <= 10'h01E;
    cyc(5);
    chk({15'h0000, lo}, 16'h0000);
    tq <= 10'h016;
    tc <= 10'h005;
    cyc(70);
    chk({15'h0000, lo}, 16'h0001);
    ofreq <= 16'h0032;
    tq <= 10'h01E;
    tc <= 10'h01E;
    cyc(150);
    chk({15'h0000, lo}, 16'h0001);
    ofreq <= 16'h0190;
    cyc(100);
    chk({15'h0000, lo}, 16'h0000);
    $display("torque detection done");
    wr(RTM_CTRL_OFS, 16'h0000);
    wr(RTM_KEYREF_OFS, 16'h1234);
    pf <= 1'b1;
    nv_wait(s, v);
    chk({15'h0000, s}, 16'h0001);
    chk(v, 16'h1234);
    pf <= 1'b0;
    wr(RTM_CTRL_OFS, 16'h0001);
    wr(RTM_KEYREF_OFS, 16'h0567);
    pf <= 1'b1;
    nv_wait(s, v);
    chk({15'h0000, s}, 16'h0000);
    pf <= 1'b0;
    sk <= 1'b1;
    nv_wait(s, v);
    chk({15'h0000, s}, 16'h0001);
    chk(v, 16'h0567);
    sk <= 1'b0;
    wr(RTM_KEYREF_OFS, 16'h0ABC);
    nvin <= 16'h0567;
    reset_n_i <= 1'b0;
    cyc(3);
    chk({rfn, ffn}, 16'h6362);
    reset_n_i <= 1'b1;
    cyc(2);
    rd(RTM_KEYREF_OFS, v);
    chk(v, 16'h0567);
    wr(RTM_SRC_OFS, 16'h0003);
    cyc(2);
    chk(reff, 16'h0567);
    $display("retention done");
    give_verdict();
  end
endmodule // tb
`default_nettype wire
